// ==== hdl/sisr_top.sv ====
// status code encoder for the line interface control port
`timescale 1ns/1ps
`default_nettype none
module sisr_top (
	input  wire logic       mclk,                 // 25 MHz system clock
	input  wire logic       rst,                  // synchronous reset, high
	input  wire logic       cclk,                 // control port serial clock
	input  wire logic       cs_n,                 // control port select, low
	input  wire logic       cdi,                  // control port data in
	output logic            cdo,                  // control port data out
	output logic            cdo_oe,               // cdo drive enable
	output logic            irq_n,                // interrupt pin, low
	output logic      [7:0] cmd_byte,             // received command
	output logic            cmd_valid,            // pulse: new command
	output logic      [7:0] status_code,          // code sent on last reply
	input  wire logic       far_end_wake,         // pulse: far end wakes
	input  wire logic       activation_pending,   // pulse: INFO seen
	input  wire logic       activation_done,      // pulse: activated
	input  wire logic       frame_alignment_lost, // pulse: alignment lost
	input  wire logic       deactivated_report,   // pulse: deactivated
	input  wire logic       dch_message_done,     // pulse: closing flag out
	input  wire logic       dch_collision_lost,   // pulse: echo mismatch
	input  wire logic       sc1_rx_ready,         // pulse: SC1/Q buffer ready
	input  wire logic [3:0] sc1_rx_bits,          // M1..M4 for SC1/Q
	input  wire logic       sc2_rx_ready,         // pulse: SC2 buffer ready
	input  wire logic [3:0] sc2_rx_bits,          // M1..M4 for SC2
	input  wire logic       mf_boundary,          // pulse: tx multiframe edge
	input  wire logic       rx_multiframe_error,  // pulse: violation or DC error
	input  wire logic       slip_tx,              // pulse: tx buffer slipped
	input  wire logic       slip_rx,              // pulse: rx buffer slipped
	input  wire logic [2:0] act_state             // activation state S3..S1
);
	localparam int NE = sisr_pkg::N_EVT;

	logic           start, done;
	logic     [7:0] rx_cmd;
	logic     [7:0] reply;
	logic [NE-1:0]  pend, set_v, clr_v, next_pend;
	logic [NE-1:0]  sent, next_sent;
	logic     [3:0] sc1_m, sc2_m, next_sc1_m, next_sc2_m;
	logic           msg_en, sc1_en, sc2_en, tick1_en, tick6_en, extra_en, state_en;
	logic           next_msg_en, next_sc1_en, next_sc2_en;
	logic           next_tick1_en, next_tick6_en, next_extra_en, next_state_en;
	logic     [2:0] six_cnt, next_six_cnt;
	logic           tick;
	logic     [7:0] next_status;
	logic           done_d;
	logic [NE-1:0]  next_held;
	logic           next_irq_n;
	logic     [7:0] idle_reply;

	// one on/off command pair steering one enable bit
	function automatic logic cmd_pair(
		input logic [7:0] code,  // received command
		input logic       cur,   // present setting
		input logic [7:0] on_c,  // command that sets it
		input logic [7:0] off_c  // command that clears it
	);
		logic res;
		res = cur;
		if (code == on_c)
			res = 1'b1;
		else if (code == off_c)
			res = 1'b0;
		return res;
	endfunction : cmd_pair

	// pins are synchronised inside the shifter; start and done are mclk pulses
	sisr_shifter u_shift (
		.mclk      (mclk),
		.rst       (rst),
		.cclk      (cclk),
		.cs_n      (cs_n),
		.cdi       (cdi),
		.load_byte (reply),
		.start     (start),
		.done      (done),
		.cmd       (rx_cmd),
		.cdo       (cdo),
		.cdo_oe    (cdo_oe)
	);

	// command decode, enables
	always_comb begin
		next_msg_en   = msg_en;
		next_sc1_en   = sc1_en;
		next_sc2_en   = sc2_en;
		next_tick1_en = tick1_en;
		next_tick6_en = tick6_en;
		next_extra_en = extra_en;
		next_state_en = state_en;
		if (done) begin
			next_msg_en   = cmd_pair(rx_cmd, msg_en,
				sisr_pkg::CMD_MSG_DONE_ON, sisr_pkg::CMD_MSG_DONE_OFF);
			next_sc1_en   = cmd_pair(rx_cmd, sc1_en,
				sisr_pkg::CMD_SC1_IRQ_ON, sisr_pkg::CMD_SC1_IRQ_OFF);
			next_sc2_en   = cmd_pair(rx_cmd, sc2_en,
				sisr_pkg::CMD_SC2_IRQ_ON, sisr_pkg::CMD_SC2_IRQ_OFF);
			next_tick1_en = cmd_pair(rx_cmd, tick1_en,
				sisr_pkg::CMD_TICK_EVERY_FRAME, sisr_pkg::CMD_TICK_FRAME_OFF);
			next_tick6_en = cmd_pair(rx_cmd, tick6_en,
				sisr_pkg::CMD_TICK_EVERY_SIX, sisr_pkg::CMD_TICK_SIX_OFF);
			next_extra_en = cmd_pair(rx_cmd, extra_en,
				sisr_pkg::CMD_EXTRA_IRQ_ENABLE, sisr_pkg::CMD_EXTRA_IRQ_DISABLE);
			next_state_en = cmd_pair(rx_cmd, state_en,
				sisr_pkg::CMD_STATE_REPORT_ON, sisr_pkg::CMD_STATE_REPORT_OFF);
		end
	end

	// tick divider counts every boundary so switching modes stays in phase
	always_comb begin
		next_six_cnt = six_cnt;
		if (mf_boundary)
			next_six_cnt = (six_cnt == sisr_pkg::TICK_SIX_LAST) ? 3'h0 : six_cnt + 3'h1;
	end

	// with both modes on the every-boundary tick wins
	always_comb begin
		tick = mf_boundary &&
			(tick1_en || (tick6_en && six_cnt == sisr_pkg::TICK_SIX_LAST));
	end

	// event capture; a set in the clearing cycle wins
	always_comb begin
		set_v = '0;
		set_v[sisr_pkg::EV_WAKE]  = far_end_wake;
		set_v[sisr_pkg::EV_ACTP]  = activation_pending;
		set_v[sisr_pkg::EV_ACTD]  = activation_done;
		set_v[sisr_pkg::EV_FRAME] = frame_alignment_lost;
		set_v[sisr_pkg::EV_DEACT] = deactivated_report;
		set_v[sisr_pkg::EV_MSG]   = dch_message_done & msg_en;
		set_v[sisr_pkg::EV_COLL]  = dch_collision_lost;
		set_v[sisr_pkg::EV_SC1]   = sc1_rx_ready & sc1_en;
		set_v[sisr_pkg::EV_SC2]   = sc2_rx_ready & sc2_en;
		set_v[sisr_pkg::EV_TICK]  = tick;
		set_v[sisr_pkg::EV_RXERR] = rx_multiframe_error & extra_en;
		set_v[sisr_pkg::EV_SLTX]  = slip_tx & extra_en;
		set_v[sisr_pkg::EV_SLRX]  = slip_rx & extra_en;
		clr_v = done ? sent : '0;
		next_pend = (pend & ~clr_v) | set_v;
		// a slot set again while its frame runs survives the frame end
		next_held = (start ? next_sent : sent) & ~set_v;
		next_irq_n = ~|next_pend;
	end

	// M bits follow the latest accepted buffer pulse
	always_comb begin
		next_sc1_m = (sc1_rx_ready && sc1_en) ? sc1_rx_bits : sc1_m;
		next_sc2_m = (sc2_rx_ready && sc2_en) ? sc2_rx_bits : sc2_m;
	end

	// idle reply; state bits only once reporting is switched on
	always_comb begin
		if (state_en)
			idle_reply = {sisr_pkg::ST_IDLE_STATE_FLAG, act_state, 4'h0};
		else
			idle_reply = sisr_pkg::ST_IDLE_NO_CHANGE;
	end

	// priority pick of the reply byte
	always_comb begin
		reply     = idle_reply;
		next_sent = '0;
		if (pend[sisr_pkg::EV_DEACT]) begin
			reply = sisr_pkg::ST_DEACTIVATED;
			next_sent[sisr_pkg::EV_DEACT] = 1'b1;
		end else if (pend[sisr_pkg::EV_FRAME]) begin
			reply = sisr_pkg::ST_FRAME_LOST;
			next_sent[sisr_pkg::EV_FRAME] = 1'b1;
		end else if (pend[sisr_pkg::EV_ACTD]) begin
			reply = sisr_pkg::ST_ACT_DONE;
			next_sent[sisr_pkg::EV_ACTD] = 1'b1;
		end else if (pend[sisr_pkg::EV_ACTP]) begin
			reply = sisr_pkg::ST_ACT_PENDING;
			next_sent[sisr_pkg::EV_ACTP] = 1'b1;
		end else if (pend[sisr_pkg::EV_WAKE]) begin
			reply = sisr_pkg::ST_FAR_END_WAKE;
			next_sent[sisr_pkg::EV_WAKE] = 1'b1;
		end else if (pend[sisr_pkg::EV_COLL]) begin
			reply = sisr_pkg::ST_COLLISION_LOST;
			next_sent[sisr_pkg::EV_COLL] = 1'b1;
		end else if (pend[sisr_pkg::EV_MSG]) begin
			reply = sisr_pkg::ST_MSG_DONE;
			next_sent[sisr_pkg::EV_MSG] = 1'b1;
		end else if (pend[sisr_pkg::EV_SC1]) begin
			reply = {sisr_pkg::ST_SC1_HIGH_NIB, sc1_m};
			next_sent[sisr_pkg::EV_SC1] = 1'b1;
		end else if (pend[sisr_pkg::EV_SC2]) begin
			reply = {sisr_pkg::ST_SC2_HIGH_NIB, sc2_m};
			next_sent[sisr_pkg::EV_SC2] = 1'b1;
		end else if (pend[sisr_pkg::EV_TICK]) begin
			reply = sisr_pkg::ST_MF_TICK;
			next_sent[sisr_pkg::EV_TICK] = 1'b1;
		end else if (pend[sisr_pkg::EV_RXERR]) begin
			reply = sisr_pkg::ST_RX_MF_ERROR;
			next_sent[sisr_pkg::EV_RXERR] = 1'b1;
		end else if (pend[sisr_pkg::EV_SLTX] || pend[sisr_pkg::EV_SLRX]) begin
			// both slips fold into one report
			reply = {sisr_pkg::ST_SLIP_BASE_HI,
			         pend[sisr_pkg::EV_SLRX], pend[sisr_pkg::EV_SLTX]};
			next_sent[sisr_pkg::EV_SLTX] = pend[sisr_pkg::EV_SLTX];
			next_sent[sisr_pkg::EV_SLRX] = pend[sisr_pkg::EV_SLRX];
		end
	end

	// status is latched in the cycle the shifter loads the same byte
	always_comb begin
		next_status = start ? reply : status_code;
	end

	// mode enables; extra reports stay off until enabled
	always_ff @(posedge mclk) begin
		if (rst) begin
			msg_en   <= 1'b1;
			sc1_en   <= 1'b0;
			sc2_en   <= 1'b0;
			tick1_en <= 1'b0;
			tick6_en <= 1'b0;
			extra_en <= 1'b0;
			state_en <= 1'b0;
		end else begin
			msg_en   <= next_msg_en;
			sc1_en   <= next_sc1_en;
			sc2_en   <= next_sc2_en;
			tick1_en <= next_tick1_en;
			tick6_en <= next_tick6_en;
			extra_en <= next_extra_en;
			state_en <= next_state_en;
		end
	end

	// free-running multiframe divider
	always_ff @(posedge mclk) begin
		if (rst)
			six_cnt <= '0;
		else
			six_cnt <= next_six_cnt;
	end

	// pending slots, slots carried by the frame in flight, interrupt pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend  <= '0;
			sent  <= '0;
			irq_n <= 1'b1;
		end else begin
			pend  <= next_pend;
			sent  <= next_held;
			irq_n <= next_irq_n;
		end
	end

	// M bits of the last accepted buffer reports
	always_ff @(posedge mclk) begin
		if (rst) begin
			sc1_m <= '0;
			sc2_m <= '0;
		end else begin
			sc1_m <= next_sc1_m;
			sc2_m <= next_sc2_m;
		end
	end

	// reply code and command strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_code <= sisr_pkg::ST_IDLE_NO_CHANGE;
			done_d      <= 1'b0;
		end else begin
			status_code <= next_status;
			done_d      <= done;
		end
	end

	assign cmd_byte  = rx_cmd;
	assign cmd_valid = done_d;
endmodule : sisr_top
`default_nettype wire

// ==== hdl/sisr_pkg.sv ====
// shared constants for the status reporter
package sisr_pkg;
	localparam int CODE_W = 8;
	localparam int NIB_W  = 4;
	localparam int BIT_CNT_W = 4;
	localparam logic [BIT_CNT_W-1:0] BYTE_BITS = 4'h8;

	// status codes
	localparam logic [7:0] ST_IDLE_NO_CHANGE   = 8'h00;
	localparam logic [7:0] ST_FAR_END_WAKE     = 8'h02;
	localparam logic [7:0] ST_ACT_PENDING      = 8'h03;
	localparam logic [7:0] ST_ACT_DONE         = 8'h0C;
	localparam logic [7:0] ST_FRAME_LOST       = 8'h0E;
	localparam logic [7:0] ST_DEACTIVATED      = 8'h0F;
	localparam logic [7:0] ST_MSG_DONE         = 8'h06;
	localparam logic [7:0] ST_COLLISION_LOST   = 8'h07;
	localparam logic [3:0] ST_SC1_HIGH_NIB     = 4'h3;
	localparam logic [3:0] ST_SC2_HIGH_NIB     = 4'h5;
	localparam logic [7:0] ST_MF_TICK          = 8'h04;
	localparam logic [7:0] ST_RX_MF_ERROR      = 8'h05;
	localparam logic [5:0] ST_SLIP_BASE_HI     = 6'h02;
	localparam logic       ST_IDLE_STATE_FLAG  = 1'b1;

	// control commands that steer the reporter
	localparam logic [7:0] CMD_MSG_DONE_ON     = 8'h10;
	localparam logic [7:0] CMD_MSG_DONE_OFF    = 8'h11;
	localparam logic [7:0] CMD_SC1_IRQ_ON      = 8'h12;
	localparam logic [7:0] CMD_SC1_IRQ_OFF     = 8'h13;
	localparam logic [7:0] CMD_TICK_EVERY_FRAME = 8'h22;
	localparam logic [7:0] CMD_TICK_FRAME_OFF  = 8'h23;
	localparam logic [7:0] CMD_TICK_EVERY_SIX  = 8'h24;
	localparam logic [7:0] CMD_TICK_SIX_OFF    = 8'h25;
	localparam logic [7:0] CMD_SC2_IRQ_ON      = 8'h26;
	localparam logic [7:0] CMD_SC2_IRQ_OFF     = 8'h27;
	localparam logic [7:0] CMD_STATE_REPORT_ON = 8'h92;
	localparam logic [7:0] CMD_STATE_REPORT_OFF = 8'h93;
	localparam logic [7:0] CMD_EXTRA_IRQ_ENABLE = 8'h94;
	localparam logic [7:0] CMD_EXTRA_IRQ_DISABLE = 8'h95;

	// last divider count of the long tick, one tick per six multiframes
	localparam logic [2:0] TICK_SIX_LAST = 3'h5;

	// pending event slots, index 0 has highest priority
	localparam int N_EVT = 13;
	localparam int EV_DEACT = 0;
	localparam int EV_FRAME = 1;
	localparam int EV_ACTD  = 2;
	localparam int EV_ACTP  = 3;
	localparam int EV_WAKE  = 4;
	localparam int EV_COLL  = 5;
	localparam int EV_MSG   = 6;
	localparam int EV_SC1   = 7;
	localparam int EV_SC2   = 8;
	localparam int EV_TICK  = 9;
	localparam int EV_RXERR = 10;
	localparam int EV_SLTX  = 11;
	localparam int EV_SLRX  = 12;
endpackage : sisr_pkg

// ==== hdl/sisr_shifter.sv ====
// serial control port shifter: samples the link pins, swaps one byte each way
`timescale 1ns/1ps
`default_nettype none
module sisr_shifter (
	input  wire logic       mclk,      // system clock
	input  wire logic       rst,       // synchronous reset
	input  wire logic       cclk,      // serial clock pin
	input  wire logic       cs_n,      // chip select pin
	input  wire logic       cdi,       // serial data in pin
	input  wire logic [7:0] load_byte, // status to send, taken on start
	output logic            start,     // pulse: select asserted
	output logic            done,      // pulse: full byte received
	output logic      [7:0] cmd,       // last command byte
	output logic            cdo,       // serial data out
	output logic            cdo_oe     // drive enable for cdo
);
	logic [1:0] cclk_s, cs_s, cdi_s;
	logic       cclk_d, cs_d;
	logic [7:0] out_sr, in_sr;
	logic [sisr_pkg::BIT_CNT_W-1:0] cnt;
	logic [7:0] next_out_sr, next_in_sr, next_cmd;
	logic [sisr_pkg::BIT_CNT_W-1:0] next_cnt;
	logic       rise, fall, sel_fall, sel_rise;

	// second stage only feeds logic
	assign rise     = cclk_s[1] & ~cclk_d;
	assign fall     = ~cclk_s[1] & cclk_d;
	assign sel_fall = ~cs_s[1] & cs_d;
	assign sel_rise = cs_s[1] & ~cs_d;

	always_comb begin
		next_out_sr = out_sr;
		next_in_sr  = in_sr;
		next_cnt    = cnt;
		next_cmd    = cmd;
		if (sel_fall) begin
			next_out_sr = load_byte;
			next_cnt    = '0;
		end else if (!cs_s[1]) begin
			if (rise && cnt != sisr_pkg::BYTE_BITS) begin
				next_in_sr = {in_sr[6:0], cdi_s[1]};
				next_cnt   = cnt + 1'b1;
			end
			if (fall)
				next_out_sr = {out_sr[6:0], 1'b0};
		end
		if (sel_rise && cnt == sisr_pkg::BYTE_BITS)
			next_cmd = in_sr;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cclk_s <= '0;
			cs_s   <= 2'h3;
			cdi_s  <= '0;
			cclk_d <= 1'b0;
			cs_d   <= 1'b1;
			out_sr <= '0;
			in_sr  <= '0;
			cnt    <= '0;
			cmd    <= '0;
			done   <= 1'b0;
			cdo_oe <= 1'b0;
		end else begin
			cclk_s <= {cclk_s[0], cclk};
			cs_s   <= {cs_s[0], cs_n};
			cdi_s  <= {cdi_s[0], cdi};
			cclk_d <= cclk_s[1];
			cs_d   <= cs_s[1];
			out_sr <= next_out_sr;
			in_sr  <= next_in_sr;
			cnt    <= next_cnt;
			cmd    <= next_cmd;
			// a short frame is dropped, the status stays pending
			done   <= sel_rise && cnt == sisr_pkg::BYTE_BITS;
			cdo_oe <= ~cs_s[1];
		end
	end

	// start is not registered: the top latches its code in the load cycle
	assign start = sel_fall;
	assign cdo   = out_sr[7];
endmodule : sisr_shifter
`default_nettype wire

// ==== tb/sisr_monitor.sv ====
// port checker for the status reporter
`timescale 1ns/1ps
`default_nettype none
module sisr_monitor (
	input wire logic       mclk,                 // system clock
	input wire logic       rst,                  // synchronous reset
	input wire logic       cdo_oe,               // cdo drive enable
	input wire logic       irq_n,                // interrupt pin
	input wire logic [7:0] cmd_byte,             // received command
	input wire logic       cmd_valid,            // command pulse
	input wire logic [7:0] status_code,          // reply code
	input wire logic       far_end_wake,         // event
	input wire logic       activation_pending,   // event
	input wire logic       activation_done,      // event
	input wire logic       frame_alignment_lost, // event
	input wire logic       deactivated_report,   // event
	input wire logic       dch_collision_lost,   // event
	input wire logic       dch_message_done,     // event
	input wire logic       sc1_rx_ready,         // event
	input wire logic       sc2_rx_ready,         // event
	input wire logic       mf_boundary,          // event
	input wire logic       rx_multiframe_error,  // event
	input wire logic       slip_tx,              // event
	input wire logic       slip_rx               // event
);
	logic [12:0] ev;
	logic        msg_on, sc1_on, tick1, extra_on;
	logic        next_msg_on, next_sc1_on, next_tick1, next_extra_on;
	assign ev = {slip_rx, slip_tx, rx_multiframe_error, mf_boundary, sc2_rx_ready, sc1_rx_ready,
		dch_message_done, dch_collision_lost, deactivated_report, frame_alignment_lost,
		activation_done, activation_pending, far_end_wake};
	// mode copies lag the design by one cycle; events never sit in that gap
	function automatic logic upd(input logic cur, input logic [7:0] on_c, input logic [7:0] off_c);
		if (!cmd_valid) return cur;
		if (cmd_byte == on_c) return 1'b1;
		if (cmd_byte == off_c) return 1'b0;
		return cur;
	endfunction : upd
	always_comb begin
		next_msg_on = upd(msg_on, sisr_pkg::CMD_MSG_DONE_ON, sisr_pkg::CMD_MSG_DONE_OFF);
		next_sc1_on = upd(sc1_on, sisr_pkg::CMD_SC1_IRQ_ON, sisr_pkg::CMD_SC1_IRQ_OFF);
		next_tick1 = upd(tick1, sisr_pkg::CMD_TICK_EVERY_FRAME, sisr_pkg::CMD_TICK_FRAME_OFF);
		next_extra_on = upd(extra_on, sisr_pkg::CMD_EXTRA_IRQ_ENABLE, sisr_pkg::CMD_EXTRA_IRQ_DISABLE);
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			{msg_on, sc1_on, tick1, extra_on} <= 4'h8;
		end else begin
			{msg_on, sc1_on, tick1, extra_on} <= {next_msg_on, next_sc1_on, next_tick1, next_extra_on};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	chk_irq_raise: assert property ((|ev[5:0]) |=> !irq_n)
		else $error("irq_n not low after line event");
	chk_msg_raise: assert property (msg_on && dch_message_done |=> !irq_n)
		else $error("message done not raised");
	chk_msg_gate: assert property (irq_n && !msg_on && ev == 13'h0040 |=> irq_n)
		else $error("message done raised while off");
	chk_sc1_gate: assert property (irq_n && !sc1_on && ev == 13'h0080 |=> irq_n)
		else $error("sc1 report raised while off");
	chk_tick_frame: assert property (tick1 && mf_boundary |=> !irq_n)
		else $error("tick not raised");
	chk_extra_gate: assert property (irq_n && !extra_on && !(|ev[9:0]) && (|ev)
		|=> irq_n)
		else $error("extra report raised while off");
	chk_extra_raise: assert property (extra_on && (|ev[12:10]) |=> !irq_n)
		else $error("extra report not raised");
	chk_irq_clear: assert property ($rose(irq_n) |-> ##[0:1] cmd_valid)
		else $error("irq_n released without command");
	chk_idle_reply: assert property ($rose(cdo_oe) && $past(irq_n) && $past(irq_n, 2)
		|-> status_code == 8'h00 || (status_code[7] && status_code[3:0] == 4'h0))
		else $error("idle reply not an idle code");
	chk_code_frame: assert property (!$stable(status_code) |-> $rose(cdo_oe))
		else $error("status code changed outside frame start");
	cover property ($rose(cdo_oe) && status_code == sisr_pkg::ST_DEACTIVATED);
	cover property (tick1 && mf_boundary);
	cover property (extra_on && slip_tx && slip_rx);
endmodule : sisr_monitor
bind sisr_top sisr_monitor i_mon (
	.mclk                 (mclk),
	.rst                  (rst),
	.cdo_oe               (cdo_oe),
	.irq_n                (irq_n),
	.cmd_byte             (cmd_byte),
	.cmd_valid            (cmd_valid),
	.status_code          (status_code),
	.far_end_wake         (far_end_wake),
	.activation_pending   (activation_pending),
	.activation_done      (activation_done),
	.frame_alignment_lost (frame_alignment_lost),
	.deactivated_report   (deactivated_report),
	.dch_collision_lost   (dch_collision_lost),
	.dch_message_done     (dch_message_done),
	.sc1_rx_ready         (sc1_rx_ready),
	.sc2_rx_ready         (sc2_rx_ready),
	.mf_boundary          (mf_boundary),
	.rx_multiframe_error  (rx_multiframe_error),
	.slip_tx              (slip_tx),
	.slip_rx              (slip_rx)
);
`default_nettype wire

// ==== tb/sisr_host_model.sv ====
// host model: drives the serial control port one frame at a time
`timescale 1ns/1ps
`default_nettype none
module sisr_host_model (
	input  wire logic mclk,   // system clock
	input  wire logic cdo,    // reply data
	input  wire logic cdo_oe, // device drives cdo
	output var  logic cclk,   // serial clock, still between frames
	output var  logic cs_n,   // select
	output var  logic cdi     // command data, msb first
);
	initial begin
		cclk = 1'b0;
		cs_n = 1'b1;
		cdi = 1'b0;
	end
	// n below 8 makes a frame the device must refuse
	task automatic xfer(input logic [7:0] c, input int n, output logic [7:0] r);
		r = 8'h00;
		@(posedge mclk) cs_n <= 1'b0;
		repeat (6) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			cdi <= c[7-i];
			repeat (4) @(posedge mclk);
			cclk <= 1'b1;
			repeat (4) @(posedge mclk);
			r = {r[6:0], cdo & cdo_oe};
			cclk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		cdi <= ~cdi;
		repeat (8) @(posedge mclk);
	endtask : xfer
endmodule : sisr_host_model
`default_nettype wire

// ==== tb/sisr_top_tb.sv ====
// self-checking testbench for the status reporter
`timescale 1ns/1ps
`default_nettype none
module sisr_top_tb;
	localparam logic [7:0] NOP = 8'h00;    // ignored by the reporter
	localparam logic [7:0] ACT_REQ = 8'h01; // stand-in code, ignored by the reporter
	localparam logic [7:0] SC1_HIGH_TX = 8'h40;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [12:0] ev = 13'h0000;
	logic [3:0]  m1 = 4'h0;
	logic [3:0]  m2 = 4'h0;
	logic [2:0]  st = 3'h0;
	logic        cclk, cs_n, cdi, cdo, cdo_oe, irq_n, cmd_valid;
	logic [7:0]  cmd_byte, status_code, rep;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;
	int          nb = 0;
	always #20 mclk = ~mclk;
	sisr_host_model i_host (.mclk(mclk), .cdo(cdo), .cdo_oe(cdo_oe), .cclk(cclk), .cs_n(cs_n),
		.cdi(cdi));
	sisr_top i_dut (.mclk(mclk), .rst(rst), .cclk(cclk), .cs_n(cs_n), .cdi(cdi), .cdo(cdo),
		.cdo_oe(cdo_oe), .irq_n(irq_n), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
		.status_code(status_code), .far_end_wake(ev[0]), .activation_pending(ev[1]),
		.activation_done(ev[2]), .frame_alignment_lost(ev[3]), .deactivated_report(ev[4]),
		.dch_collision_lost(ev[5]), .dch_message_done(ev[6]), .sc1_rx_ready(ev[7]),
		.sc1_rx_bits(m1), .sc2_rx_ready(ev[8]), .sc2_rx_bits(m2), .mf_boundary(ev[9]),
		.rx_multiframe_error(ev[10]), .slip_tx(ev[11]), .slip_rx(ev[12]), .act_state(st));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [7:0] c, input logic [7:0] exp);
		i_host.xfer(c, 8, rep);
		check("reply", rep, exp);
		check("status_code", status_code, exp);
		check("cmd_byte", cmd_byte, c);
	endtask : rd
	task automatic fire(input logic [12:0] m, input logic irq_exp);
		@(posedge mclk) ev <= m;
		@(posedge mclk) ev <= 13'h0000;
		@(posedge mclk);
		check("irq_n", {7'h00, irq_n}, {7'h00, irq_exp});
	endtask : fire
	task automatic t_codes();
		logic [7:0] exp [7] = '{8'h02, 8'h03, 8'h0C, 8'h0E, 8'h0F, 8'h07, 8'h06};
		check("status_code", status_code, 8'h00);
		rd(NOP, 8'h00);
		for (int k = 0; k < 7; k++) begin
			fire(13'h0001 << k, 1'b0);
			rd(NOP, exp[k]);
			rd(k == 1 ? ACT_REQ : NOP, 8'h00);
		end
		fire(13'h0011, 1'b0);
		rd(NOP, sisr_pkg::ST_DEACTIVATED);
		i_host.xfer(NOP, 7, rep);
		check("irq_n", {7'h00, irq_n}, 8'h00);
		rd(NOP, sisr_pkg::ST_FAR_END_WAKE);
		rd(NOP, 8'h00);
		$display("test codes done");
	endtask : t_codes
	task automatic t_gates();
		logic [12:0] sm [3] = '{13'h0800, 13'h1000, 13'h1800};
		rd(sisr_pkg::CMD_MSG_DONE_OFF, 8'h00);
		fire(13'h0040, 1'b1);
		rd(sisr_pkg::CMD_MSG_DONE_ON, 8'h00);
		fire(13'h1C00, 1'b1);
		rd(sisr_pkg::CMD_EXTRA_IRQ_ENABLE, 8'h00);
		fire(13'h0400, 1'b0);
		rd(NOP, sisr_pkg::ST_RX_MF_ERROR);
		rd(SC1_HIGH_TX, 8'h00);
		for (int k = 0; k < 3; k++) begin
			fire(sm[k], 1'b0);
			rd(NOP, 8'h09 + k[7:0]);
		end
		rd(sisr_pkg::CMD_EXTRA_IRQ_DISABLE, 8'h00);
		$display("test gates done");
	endtask : t_gates
	task automatic t_sc();
		@(posedge mclk) m1 <= 4'hA;
		fire(13'h0080, 1'b1);
		rd(sisr_pkg::CMD_SC1_IRQ_ON, 8'h00);
		fire(13'h0080, 1'b0);
		rd(sisr_pkg::CMD_SC1_IRQ_OFF, {sisr_pkg::ST_SC1_HIGH_NIB, 4'hA});
		@(posedge mclk) m2 <= 4'h5;
		rd(sisr_pkg::CMD_SC2_IRQ_ON, 8'h00);
		fire(13'h0100, 1'b0);
		rd(sisr_pkg::CMD_SC2_IRQ_OFF, {sisr_pkg::ST_SC2_HIGH_NIB, 4'h5});
		fire(13'h0100, 1'b1);
		rd(NOP, 8'h00);
		$display("test sc done");
	endtask : t_sc
	task automatic t_tick();
		rd(sisr_pkg::CMD_TICK_EVERY_FRAME, 8'h00);
		fire(13'h0200, 1'b0);
		nb++;
		rd(sisr_pkg::CMD_TICK_FRAME_OFF, sisr_pkg::ST_MF_TICK);
		rd(sisr_pkg::CMD_TICK_EVERY_SIX, 8'h00);
		for (int k = 0; k < 7; k++) begin
			fire(13'h0200, (nb % 6) != 5);
			rd(NOP, (nb % 6) == 5 ? sisr_pkg::ST_MF_TICK : 8'h00);
			nb++;
		end
		rd(sisr_pkg::CMD_TICK_SIX_OFF, 8'h00);
		$display("test tick done");
	endtask : t_tick
	task automatic t_state();
		@(posedge mclk) st <= 3'h5;
		rd(sisr_pkg::CMD_STATE_REPORT_ON, 8'h00);
		rd(NOP, 8'hD0);
		rd(sisr_pkg::CMD_STATE_REPORT_OFF, 8'hD0);
		rd(NOP, 8'h00);
		$display("test state done");
	endtask : t_state
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_codes();
		t_gates();
		t_sc();
		t_tick();
		t_state();
		wrap_up();
	end
endmodule : sisr_top_tb
`default_nettype wire
